/* File: ebrw_mem_model.sv */
// far-side memory model with a programmable ready release
`timescale 1ns/1ps
`include "ebrw_params.svh"

module ebrw_mem_model (
    // link clock and bus pins of the unit
    input  wire logic                    clock,
    input  wire ebrw_pkg::ebrw_pins_s    busPins,
    // access cycle at which ready rises, 0 keeps it high
    input  wire logic [7:0]              relAt,
    // answers towards the unit
    output logic                         extWaitRelease,
    output logic [`EBRW_XD_W-1:0]        extDataIn
);
    import ebrw_pkg::*;

    logic [15:0] mem [0:255];
    logic [7:0]  cnt;
    logic [15:0] junk;

    initial begin
        cnt = 8'h00;
        junk = 16'h0000;
        extWaitRelease = 1'b0;
        // a known fill, so a write that never strobes still reads back defined data
        for (int k = 0; k < 256; k++) mem[k] = {8'hc3, 8'(k) ^ 8'hc3};
    end

    // a released data bus flips every cycle, so stale data never passes
    assign extDataIn = busPins.extReadStrobeN ? junk : mem[busPins.extAddressBus[7:0]];

    // cycle count of the access, ready release and write capture
    always @(posedge clock) begin
        junk <= ~junk;
        cnt <= busPins.zoneSelectN ? 8'h00 : cnt + 8'h01;
        extWaitRelease <= (relAt == 8'h00) || (!busPins.zoneSelectN && cnt + 8'h01 >= relAt);
        if (!busPins.extWriteStrobeN && !busPins.extDataOeN) begin
            mem[busPins.extAddressBus[7:0]] <= busPins.extDataOut;
        end
    end
endmodule : ebrw_mem_model

/* File: ebrw_params.svh */
// constants of the external bus ready and wait-state logic
`ifndef EBRW_PARAMS_SVH
`define EBRW_PARAMS_SVH

// ****************************************************************
// widths
// ****************************************************************
`define EBRW_REG_AW        5
`define EBRW_XA_W          19
`define EBRW_XD_W          16
`define EBRW_CNT_W         8

// ****************************************************************
// register offsets (byte addresses on the plain register port)
// ****************************************************************
`define EBRW_OFF_CONFIG    5'h00
`define EBRW_OFF_ADDR      5'h04
`define EBRW_OFF_WDATA     5'h08
`define EBRW_OFF_COMMAND   5'h0c
`define EBRW_OFF_STATUS    5'h10

// ****************************************************************
// field positions and reset values
// ****************************************************************
`define EBRW_CMD_START     0
`define EBRW_CMD_READ      1
`define EBRW_STAT_BUSY     0
`define EBRW_STAT_LASTRD   1
`define EBRW_STAT_RDATA    16
`define EBRW_CONFIG_RST    16'h16ad
`define EBRW_CNT_MAX       8'hff

`endif

/* File: ebrw_pkg.sv */
// types of the external bus ready and wait-state logic
`include "ebrw_params.svh"

package ebrw_pkg;

    // zone timing configuration word, high bits first in the register
    typedef struct packed {
        logic       waitSampleStyle;   // 0 synchronous, 1 asynchronous
        logic       waitInputEnable;
        logic [1:0] writeTrailCount;
        logic [2:0] writeActiveCount;
        logic [1:0] writeLeadCount;
        logic [1:0] readTrailCount;
        logic [2:0] readActiveCount;
        logic [1:0] readLeadCount;
    } ebrw_cfg_s;

    // one access as handed from the register side to the link side
    typedef struct packed {
        ebrw_cfg_s                cfg;
        logic                     rd;
        logic [`EBRW_XA_W-1:0]    addr;
        logic [`EBRW_XD_W-1:0]    wdata;
    } ebrw_cmd_s;

    // phase counts of the access in progress, already widened
    typedef struct packed {
        logic [`EBRW_CNT_W-1:0]   lead;
        logic [`EBRW_CNT_W-1:0]   act;
        logic [`EBRW_CNT_W-1:0]   trail;
    } ebrw_tim_s;

    // external bus pins driven by the block
    typedef struct packed {
        logic                     busOutClock;
        logic                     zoneSelectN;
        logic                     extReadStrobeN;
        logic                     extWriteStrobeN;
        logic                     extDirSignal;
        logic [`EBRW_XA_W-1:0]    extAddressBus;
        logic [`EBRW_XD_W-1:0]    extDataOut;
        logic                     extDataOeN;
    } ebrw_pins_s;

    typedef enum logic [4:0] {
        LS_IDLE   = 5'h01,
        LS_ALIGN  = 5'h02,
        LS_LEAD   = 5'h04,
        LS_ACTIVE = 5'h08,
        LS_TRAIL  = 5'h10
    } ebrw_lstate_e;

endpackage : ebrw_pkg

/* File: ebrw_sync2.sv */
// two-flop synchroniser for levels and held words
`timescale 1ns/1ps

module ebrw_sync2 #(
    parameter int W = 1
) (
    // clock of the receiving domain
    input  wire logic         clock,
    // level to bring across, and its synchronised copy
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } ebrw_sync_s;

    ebrw_sync_s st_q;
    ebrw_sync_s st_d;

    // first stage feeds only the second stage
    always_comb begin
        st_d    = st_q;
        st_d.s1 = d;
        st_d.s2 = st_q.s1;
    end

    always_ff @(posedge clock) begin
        st_q <= st_d;
    end

    assign q = st_q.s2;

endmodule : ebrw_sync2

/* File: ebrw_tb_top.sv */
// self-checking bench of the external bus unit
`timescale 1ns/1ps
`include "ebrw_params.svh"

module ebrw_tb_top;
    import ebrw_pkg::*;

    logic        clock = 1'b0;
    logic        lclk  = 1'b0;
    logic        srst  = 1'b1;
    logic [4:0]  regAddr;
    logic [31:0] regWdata, regRdata;
    logic        regWr, regRd, rdTag, rdDly, ready, run, holdBad, wrOk;
    logic [15:0] dIn, wd, lastRd;
    logic [7:0]  relAt, len, act;
    logic [18:0] curA, holdA;
    ebrw_pins_s  pins;
    logic [31:0] expRd[$];
    logic [7:0]  expLen[$], expAct[$];
    int          errors = 0, cmp_count = 0, seed = 57, cyc = 0;

    always #25 clock = ~clock;
    initial #13 forever #80 lclk = ~lclk;

    ebrw_top dut (.clock, .srst, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
                  .interfaceTimingClock(lclk), .extWaitRelease(ready), .extDataIn(dIn),
                  .busPins(pins));
    ebrw_mem_model mem (.clock(lclk), .busPins(pins), .relAt, .extWaitRelease(ready),
                        .extDataIn(dIn));

    // ************************************************************
    // compare tasks and verdict
    // ************************************************************
    task automatic chkReg(input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("Error regRdata expected %h seen %h", e, g);
        end
    endtask : chkReg

    task automatic chkBus(input string n, input logic [18:0] e, input logic [18:0] g);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chkBus

    task automatic results;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : results

    // ************************************************************
    // register port master, changes right after the rising edge
    // ************************************************************
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge clock);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clock);
        regWr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [4:0] a, input logic chk, input logic [31:0] e);
        @(posedge clock);
        regAddr <= a;
        regRd <= 1'b1;
        rdTag <= chk;
        if (chk) expRd.push_back(e);
        @(posedge clock);
        regRd <= 1'b0;
    endtask : rd

    // poll busy with a bounded count; a hang is left to the busy bit of the status check
    task automatic waitIdle;
        for (int k = 0; k < 300; k++) begin
            rd(`EBRW_OFF_STATUS, 1'b0, 32'h0);
            #1;
            if (regRdata[0] === 1'b0) break;
        end
    endtask : waitIdle

    // ************************************************************
    // watchers: read data and bus pins
    // ************************************************************
    always @(posedge clock) begin
        rdDly <= regRd && rdTag;
        if (rdDly) chkReg(expRd.pop_front(), regRdata);
        cyc++;
        if (cyc == 20000) begin
            errors++;
            results();
        end
    end

    always @(posedge lclk) begin
        if (run && !pins.zoneSelectN) begin
            if (len == 8'h00) begin
                chkBus("busOutClock", 19'h1, {18'h0, pins.busOutClock});
                chkBus("address", curA, pins.extAddressBus);
                holdA <= pins.extAddressBus;
            end
            len <= len + 8'h01;
            act <= act + {7'h0, !(pins.extReadStrobeN & pins.extWriteStrobeN)};
        end else if (run && len != 8'h00) begin
            chkBus("length", expLen.pop_front(), len);
            chkBus("active", expAct.pop_front(), act);
            len <= 8'h00;
            act <= 8'h00;
        end
        if (run && pins.zoneSelectN && pins.extAddressBus !== holdA) holdBad <= 1'b1;
    end

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin : mainSeq
        logic [1:0] L, T;
        logic [2:0] A;
        logic [7:0] R;
        logic [15:0] cfg;
        int lp, ext, n;
        regAddr = 5'h00; regWdata = 32'h0; regWr = 1'b0; regRd = 1'b0; rdTag = 1'b0;
        rdDly = 1'b0; relAt = 8'h00; run = 1'b0; holdBad = 1'b0; holdA = 19'h0;
        len = 8'h00; act = 8'h00; lastRd = 16'h0; curA = 19'h0; wd = 16'h0;
        repeat (5) @(posedge clock);
        srst <= 1'b0;
        repeat (20) @(posedge clock);
        run <= 1'b1;
        rd(`EBRW_OFF_CONFIG, 1'b1, 32'h16ad);
        wr(5'h14, 32'hffffffff);
        rd(5'h14, 1'b1, 32'h0);
        $display("test registers done");
        for (int i = 0; i < 16; i++) begin
            L = 2'($random(seed));
            T = 2'($random(seed));
            A = 3'($random(seed));
            if (i[2] && A < 3'd2) A = A + 3'd2;
            // read data lags two flops, so a read needs three strobe cycles
            if (i[0] && A < 3'd3) A = A + 3'd3;
            R = 8'($random(seed)) & 8'h0f;
            if (!i[0]) begin
                curA = 19'($random(seed));
                wd = 16'($random(seed));
                curA[7:0] = 8'(i);              // no two write tests share a word
                wrOk = i[2] || (A != 3'd0);     // no active phase, no write strobe
            end
            lp = (L == 2'd0) ? 1 : L;
            ext = R - (lp + A - (i[1] ? 3 : 1));
            if (ext < 0) ext = 0;
            n = lp + A + T + (i[2] ? (i[1] ? 0 : 2) + ext : 0);
            cfg = {i[1], i[2], T, A, L, T, A, L};
            wr(`EBRW_OFF_CONFIG, {16'h0, cfg});
            if (i == 0) rd(`EBRW_OFF_CONFIG, 1'b1, {16'h0, cfg});
            wr(`EBRW_OFF_ADDR, {13'h0, curA});
            wr(`EBRW_OFF_WDATA, {16'h0, wd});
            relAt <= R;
            expLen.push_back(8'(n));
            expAct.push_back(8'(n - lp - T));
            repeat (($random(seed) & 7) + 1) @(posedge clock);
            wr(`EBRW_OFF_COMMAND, {30'h0, i[0], 1'b1});
            // a second start while busy must be dropped
            wr(`EBRW_OFF_COMMAND, {30'h0, i[0], 1'b1});
            waitIdle();
            if (i[0]) lastRd = wrOk ? wd : {8'hc3, curA[7:0] ^ 8'hc3};
            rd(`EBRW_OFF_STATUS, 1'b1, {lastRd, 14'h0, i[0], 1'b0});
            $display("test access %0d done", i);
        end
        repeat (10) @(posedge clock);
        chkBus("address hold", 19'h0, {18'h0, holdBad});
        results();
    end
endmodule : ebrw_tb_top

/* File: ebrw_top.sv */
// external bus unit: access sequencer with wait-state and ready sampling
`timescale 1ns/1ps
`include "ebrw_params.svh"

module ebrw_top (
    // system clock and reset
    input  wire logic                      clock,
    input  wire logic                      srst,
    // register port
    input  wire logic [`EBRW_REG_AW-1:0]   regAddr,
    input  wire logic [31:0]               regWdata,
    input  wire logic                      regWr,
    input  wire logic                      regRd,
    output logic      [31:0]               regRdata,
    // interface timing clock, the link domain
    input  wire logic                      interfaceTimingClock,
    // external bus
    input  wire logic                      extWaitRelease,
    input  wire logic [`EBRW_XD_W-1:0]     extDataIn,
    output ebrw_pkg::ebrw_pins_s           busPins
);
    import ebrw_pkg::*;

    // ****************************************************************
    // helpers
    // ****************************************************************

    // counts of the selected direction; a zero lead is run as one
    function automatic ebrw_tim_s pickTiming(input ebrw_cmd_s c);
        ebrw_tim_s t;
        t = '0;
        if (c.rd) begin
            t.lead  = {6'h00, c.cfg.readLeadCount};
            t.act   = {5'h00, c.cfg.readActiveCount};
            t.trail = {6'h00, c.cfg.readTrailCount};
        end else begin
            t.lead  = {6'h00, c.cfg.writeLeadCount};
            t.act   = {5'h00, c.cfg.writeActiveCount};
            t.trail = {6'h00, c.cfg.writeTrailCount};
        end
        if (t.lead == 8'h00) begin
            t.lead = 8'h01;
        end
        return t;
    endfunction : pickTiming
    // count of the last active cycle with no wait: lead + active - 1
    function automatic logic [7:0] lastActive(input ebrw_tim_s t);
        return 8'(t.lead + t.act - 8'h01);
    endfunction : lastActive
    // cycle in which the synchronised ready of the first sample is seen;
    // the pin is sampled at edge E and reaches the logic one cycle later
    function automatic logic [7:0] decideCount(input ebrw_tim_s t, input logic asyncStyle);
        if (asyncStyle) begin
            return 8'(t.lead + t.act - 8'h01);    // E = lead + active - 2
        end
        return 8'(t.lead + t.act + 8'h01);        // E = lead + active
    endfunction : decideCount
    function automatic logic [7:0] satInc(input logic [7:0] v);
        return (v == `EBRW_CNT_MAX) ? v : 8'(v + 8'h01);
    endfunction : satInc

    // ****************************************************************
    // system-side state
    // ****************************************************************
    typedef struct packed {
        ebrw_cfg_s               cfg;
        logic [`EBRW_XA_W-1:0]   addr;
        logic [`EBRW_XD_W-1:0]   wdata;
        ebrw_cmd_s               cmd;      // frozen copy for the link side
        logic                    busy;
        logic                    reqTgl;
        logic                    ackSeen;
        logic [`EBRW_XD_W-1:0]   rdata;
        logic [31:0]             rdOut;
    } ebrw_sys_s;

    // ****************************************************************
    // link-side state
    // ****************************************************************
    typedef struct packed {
        ebrw_lstate_e            st;
        logic                    phase;    // bus output clock level
        logic [`EBRW_CNT_W-1:0]  cnt;
        ebrw_cmd_s               cmd;
        logic                    reqSeen;
        logic                    ackTgl;
        logic [`EBRW_XD_W-1:0]   rdata;
        ebrw_pins_s              pins;
    } ebrw_link_s;

    ebrw_sys_s               s_q;
    ebrw_sys_s               s_d;
    ebrw_link_s              l_q;
    ebrw_link_s              l_d;
    logic                    linkRst;
    logic                    reqSync;
    logic                    ackSync;
    logic                    readySync;
    logic [`EBRW_XD_W-1:0]   dataSync;
    ebrw_tim_s               tim;
    logic                    leaveAct;
    logic                    finish;

    // ****************************************************************
    // crossings
    // ****************************************************************

    // reset reaches the link domain as a level
    ebrw_sync2 #(.W(1)) u_rstSync (
        .clock (interfaceTimingClock),
        .d     (srst),
        .q     (linkRst)
    );
    // start request as a toggle; the command word is held until acked
    ebrw_sync2 #(.W(1)) u_reqSync (
        .clock (interfaceTimingClock),
        .d     (s_q.reqTgl),
        .q     (reqSync)
    );
    // ready pin, two stages; the async style counts for their delay
    ebrw_sync2 #(.W(1)) u_readySync (
        .clock (interfaceTimingClock),
        .d     (extWaitRelease),
        .q     (readySync)
    );
    // read data held by the far device while the read strobe is low
    ebrw_sync2 #(.W(`EBRW_XD_W)) u_dataSync (
        .clock (interfaceTimingClock),
        .d     (extDataIn),
        .q     (dataSync)
    );
    // completion toggle back; read data stands still behind it
    ebrw_sync2 #(.W(1)) u_ackSync (
        .clock (clock),
        .d     (l_q.ackTgl),
        .q     (ackSync)
    );

    // ****************************************************************
    // register port
    // ****************************************************************

    // a start while busy is dropped so the frozen command never moves
    always_comb begin
        s_d       = s_q;
        s_d.rdOut = 32'h0000_0000;
        if (ackSync != s_q.ackSeen) begin
            s_d.ackSeen = ackSync;
            s_d.busy    = 1'b0;
            s_d.rdata   = l_q.rdata;
        end
        if (regWr) begin
            unique case (regAddr)
                `EBRW_OFF_CONFIG: s_d.cfg   = ebrw_cfg_s'(regWdata[15:0]);
                `EBRW_OFF_ADDR:   s_d.addr  = regWdata[`EBRW_XA_W-1:0];
                `EBRW_OFF_WDATA:  s_d.wdata = regWdata[`EBRW_XD_W-1:0];
                `EBRW_OFF_COMMAND: begin
                    if (regWdata[`EBRW_CMD_START] && !s_q.busy) begin
                        s_d.cmd.cfg   = s_q.cfg;
                        s_d.cmd.addr  = s_q.addr;
                        s_d.cmd.wdata = s_q.wdata;
                        s_d.cmd.rd    = regWdata[`EBRW_CMD_READ];
                        s_d.busy      = 1'b1;
                        s_d.reqTgl    = ~s_q.reqTgl;
                    end
                end
                default: ;
            endcase
        end
        if (regRd) begin
            unique case (regAddr)
                `EBRW_OFF_CONFIG: s_d.rdOut = {16'h0000, s_q.cfg};
                `EBRW_OFF_ADDR:   s_d.rdOut = {13'h0000, s_q.addr};
                `EBRW_OFF_WDATA:  s_d.rdOut = {16'h0000, s_q.wdata};
                `EBRW_OFF_STATUS: begin
                    s_d.rdOut[`EBRW_STAT_BUSY]                     = s_q.busy;
                    s_d.rdOut[`EBRW_STAT_LASTRD]                   = s_q.cmd.rd;
                    s_d.rdOut[`EBRW_STAT_RDATA+:`EBRW_XD_W]        = s_q.rdata;
                end
                default: s_d.rdOut = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            s_q         <= '0;
            s_q.cfg     <= ebrw_cfg_s'(`EBRW_CONFIG_RST);
        end else begin
            s_q <= s_d;
        end
    end

    assign regRdata = s_q.rdOut;

    // ****************************************************************
    // access sequencer on the timing clock
    // ****************************************************************
    assign tim = pickTiming(l_q.cmd);

    // the bus output clock runs at half the timing clock; a lead phase
    // may only begin where it rises, which is when phase goes 0 to 1
    always_comb begin
        l_d      = l_q;
        l_d.phase = ~l_q.phase;
        leaveAct = 1'b0;
        finish   = 1'b0;
        unique case (l_q.st)
            LS_IDLE: begin
                if (reqSync != l_q.reqSeen) begin
                    l_d.reqSeen = reqSync;
                    l_d.cmd     = s_q.cmd;
                    l_d.cnt     = 8'h00;
                    if (!l_q.phase) begin
                        l_d.st = LS_LEAD;
                    end else begin
                        l_d.st = LS_ALIGN;
                    end
                end
            end
            LS_ALIGN: begin
                l_d.st  = LS_LEAD;
                l_d.cnt = 8'h00;
            end
            LS_LEAD: begin
                l_d.cnt = satInc(l_q.cnt);
                if (l_q.cnt == 8'(tim.lead - 8'h01)) begin
                    if (tim.act == 8'h00 && !l_q.cmd.cfg.waitInputEnable) begin
                        leaveAct = 1'b1;
                    end else begin
                        l_d.st = LS_ACTIVE;
                    end
                end
            end
            LS_ACTIVE: begin
                l_d.cnt = satInc(l_q.cnt);
                // ready is looked at from the first sample on, once a cycle
                if (l_q.cnt >= lastActive(tim)) begin
                    if (!l_q.cmd.cfg.waitInputEnable) begin
                        leaveAct = 1'b1;
                    end else if (l_q.cnt >= decideCount(tim, l_q.cmd.cfg.waitSampleStyle)
                                 && readySync) begin
                        leaveAct = 1'b1;
                    end
                end
            end
            LS_TRAIL: begin
                l_d.cnt = satInc(l_q.cnt);
                if (l_q.cnt == 8'(tim.trail - 8'h01)) begin
                    finish = 1'b1;
                end
            end
            default: l_d.st = LS_IDLE;
        endcase
        // with the wait input enabled, a low ready keeps the state in active: the far side relies on it
        if (leaveAct) begin
            if (l_q.cmd.rd) begin
                l_d.rdata = dataSync;
            end
            if (tim.trail != 8'h00) begin
                l_d.st  = LS_TRAIL;
                l_d.cnt = 8'h00;
            end else begin
                finish = 1'b1;
            end
        end
        if (finish) begin
            l_d.st     = LS_IDLE;
            l_d.ackTgl = ~l_q.ackTgl;
        end
        // address only moves when a lead phase begins, never otherwise
        if (l_d.st == LS_LEAD && l_q.st != LS_LEAD) begin
            l_d.pins.extAddressBus = l_d.cmd.addr;
        end
        // pins are registered copies of the next state
        l_d.pins.busOutClock     = l_d.phase;
        l_d.pins.zoneSelectN     = !(l_d.st inside {LS_LEAD, LS_ACTIVE, LS_TRAIL});
        l_d.pins.extReadStrobeN  = !(l_d.st == LS_ACTIVE && l_d.cmd.rd);
        l_d.pins.extWriteStrobeN = !(l_d.st == LS_ACTIVE && !l_d.cmd.rd);
        l_d.pins.extDirSignal    = !(l_d.st inside {LS_LEAD, LS_ACTIVE, LS_TRAIL}
                                     && !l_d.cmd.rd);
        l_d.pins.extDataOeN      = !(l_d.st inside {LS_LEAD, LS_ACTIVE, LS_TRAIL}
                                     && !l_d.cmd.rd);
        l_d.pins.extDataOut      = l_d.cmd.wdata;
    end

    always_ff @(posedge interfaceTimingClock) begin
        if (linkRst) begin
            l_q                      <= '0;
            l_q.st                   <= LS_IDLE;
            l_q.pins.zoneSelectN     <= 1'b1;
            l_q.pins.extReadStrobeN  <= 1'b1;
            l_q.pins.extWriteStrobeN <= 1'b1;
            l_q.pins.extDirSignal    <= 1'b1;
            l_q.pins.extDataOeN      <= 1'b1;
        end else begin
            l_q <= l_d;
        end
    end

    assign busPins = l_q.pins;

    // ****************************************************************
    // checks
    // ****************************************************************

    lead_on_rise_a: assert property (
        @(posedge interfaceTimingClock) disable iff (linkRst)
        (l_q.st == LS_LEAD && $past(l_q.st) != LS_LEAD)
            |-> (l_q.pins.busOutClock && !$past(l_q.pins.busOutClock)))
        else $error("lead phase began off the rising bus clock");
    align_quiet_a: assert property (
        @(posedge interfaceTimingClock) disable iff (linkRst)
        l_q.st == LS_ALIGN |-> (l_q.pins.zoneSelectN && l_q.pins.extReadStrobeN
            && l_q.pins.extWriteStrobeN && l_q.pins.extDirSignal && l_q.pins.extDataOeN))
        else $error("control active in an alignment cycle");
    addr_hold_a: assert property (
        @(posedge interfaceTimingClock) disable iff (linkRst)
        (!$past(linkRst) && !$fell(l_q.pins.zoneSelectN))
            |-> $stable(l_q.pins.extAddressBus))
        else $error("address moved outside the start of a lead phase");
    sync_wait_a: assert property (
        @(posedge interfaceTimingClock) disable iff (linkRst)
        (l_q.st == LS_ACTIVE && l_q.cmd.cfg.waitInputEnable && !l_q.cmd.cfg.waitSampleStyle
            && l_q.cnt < 8'(tim.lead + tim.act + 8'h01)) |=> l_q.st == LS_ACTIVE)
        else $error("synchronous ready sampled before its first point");
    async_first_a: assert property (
        @(posedge interfaceTimingClock) disable iff (linkRst)
        (l_q.st == LS_ACTIVE && l_q.cmd.cfg.waitInputEnable && l_q.cmd.cfg.waitSampleStyle
            && l_q.cnt == 8'(tim.lead + tim.act - 8'h01) && readySync)
            |=> l_q.st != LS_ACTIVE)
        else $error("asynchronous first sample high did not end active");
    ready_high_a: assert property (
        @(posedge interfaceTimingClock) disable iff (linkRst)
        (l_q.st == LS_ACTIVE && l_q.cnt >= lastActive(tim)
            && l_q.cnt >= decideCount(tim, l_q.cmd.cfg.waitSampleStyle) && readySync)
            |=> l_q.st inside {LS_TRAIL, LS_IDLE})
        else $error("active phase stretched past a high ready");
    ready_low_a: assert property (
        @(posedge interfaceTimingClock) disable iff (linkRst)
        (l_q.st == LS_ACTIVE && l_q.cmd.cfg.waitInputEnable && !readySync)
            |=> (l_q.st == LS_ACTIVE && !l_q.pins.zoneSelectN))
        else $error("access ended while ready was low");
    no_wait_a: assert property (
        @(posedge interfaceTimingClock) disable iff (linkRst)
        (l_q.st == LS_ACTIVE && !l_q.cmd.cfg.waitInputEnable && l_q.cnt == lastActive(tim))
            |=> l_q.st != LS_ACTIVE)
        else $error("ready not ignored with wait input disabled");
    ready_sync_a: assert property (
        @(posedge interfaceTimingClock) disable iff (linkRst)
        $past(linkRst, 2) == 1'b0 |-> readySync == $past(extWaitRelease, 2))
        else $error("ready synchroniser depth is not two");

endmodule : ebrw_top
